// ---- rtl/cbu_branch_unit.sv ----
// Notes on behaviour
// - branch_on_status_bit_set: if flag s is one, pc becomes pc plus k plus one.
// - branch_on_status_bit_clear: if flag s is zero, pc becomes pc plus k plus one.
// - branch_on_carry_clear is taken only when carry is zero.
// - branch_on_same_or_higher tests carry, taken when carry is zero.
// - branch_on_signed_ge taken when negative xor overflow is zero.
// - branch_on_signed_lt taken when negative xor overflow is one.
// - branch_on_half_carry_set taken when half carry is one, else falls through.
// - branch_on_half_carry_clear taken when half carry is zero, else falls through.
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module cbu_branch_unit
  import cbu_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // register bus
  input wire cbu_axi_req_s axi_i,
  output cbu_axi_rsp_s axi_o,
  // core state
  output logic [PC_W-1:0] pc_o,
  output logic busy_o
);
  function automatic logic cond_f(input cbu_op_e op, input logic [2:0] s,
                                  input logic [7:0] f);
    case (op)
      OP_BIT_SET: cond_f = f[s];
      OP_BIT_CLEAR: cond_f = !f[s];
      OP_EQ: cond_f = f[FLAG_Z];
      OP_NE: cond_f = !f[FLAG_Z];
      OP_CS, OP_LO: cond_f = f[FLAG_C];
      OP_CC: cond_f = !f[FLAG_C];
      OP_SH: cond_f = !f[FLAG_C];
      OP_MI: cond_f = f[FLAG_N];
      OP_PL: cond_f = !f[FLAG_N];
      OP_GE: cond_f = !(f[FLAG_N] ^ f[FLAG_V]);
      OP_LT: cond_f = f[FLAG_N] ^ f[FLAG_V];
      OP_HS: cond_f = f[FLAG_H];
      OP_HC: cond_f = !f[FLAG_H];
      OP_TS: cond_f = f[FLAG_T];
      default: cond_f = 1'b0;
    endcase
  endfunction : cond_f

  // bus state
  cbu_axi_rsp_s rsp_q, rsp_d;
  logic aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [AW-1:0] awaddr_q, awaddr_d;
  logic [DW-1:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  // branch state
  cbu_state_e state_q, state_d;
  logic busy_q, busy_d, taken_q, taken_d;
  logic [PC_W-1:0] pc_q, pc_d, tgt_q, tgt_d;
  logic [7:0] flags_q, flags_d;
  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  // decoded write
  logic wr_go, start_w, cmd_cond;
  cbu_op_e cmd_op;
  logic [2:0] cmd_s;
  logic [K_W-1:0] cmd_k;
  logic [PC_W-1:0] cmd_tgt, cmd_next;
  logic [DW-1:0] wmask;

  always_comb begin
    wr_go = aw_held_q && w_held_q && !rsp_q.bvalid;
    cmd_op = cbu_op_e'(wdata_q[CTRL_OP_LSB +: 4]);
    cmd_s = wdata_q[CTRL_S_LSB +: 3];
    cmd_k = wdata_q[CTRL_K_LSB +: K_W];
    start_w = wr_go && (awaddr_q == OFF_CTRL) && (state_q == ST_IDLE);
    cmd_cond = cond_f(cmd_op, cmd_s, flags_q);
    cmd_next = PC_W'(pc_q + 1'b1);
    cmd_tgt = PC_W'(pc_q + {{(PC_W-K_W){cmd_k[K_W-1]}}, cmd_k} + 1'b1);
    wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  end

  // bus slave: address and data accepted in either order
  always_comb begin
    rsp_d = rsp_q;
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    if (axi_i.awvalid && rsp_q.awready) begin
      aw_held_d = 1'b1;
      awaddr_d = axi_i.awaddr;
    end
    if (axi_i.wvalid && rsp_q.wready) begin
      w_held_d = 1'b1;
      wdata_d = axi_i.wdata;
      wstrb_d = axi_i.wstrb;
    end
    if (rsp_q.bvalid && axi_i.bready) begin
      rsp_d.bvalid = 1'b0;
    end
    if (wr_go) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      rsp_d.bvalid = 1'b1;
      // writes to pc, flags or ctrl while a taken branch completes are refused; status writes always get OKAY
      if (awaddr_q == OFF_STAT) begin
        rsp_d.bresp = RESP_OKAY;
      end else if (awaddr_q == OFF_PC || awaddr_q == OFF_FLAGS || awaddr_q == OFF_CTRL) begin
        rsp_d.bresp = (state_q == ST_IDLE) ? RESP_OKAY : RESP_SLVERR;
      end else begin
        rsp_d.bresp = RESP_SLVERR;
      end
    end
    rsp_d.awready = !aw_held_d && !rsp_d.bvalid;
    rsp_d.wready = !w_held_d && !rsp_d.bvalid;
    if (rsp_q.rvalid && axi_i.rready) begin
      rsp_d.rvalid = 1'b0;
    end
    if (axi_i.arvalid && rsp_q.arready) begin
      rsp_d.rvalid = 1'b1;
      rsp_d.rresp = RESP_OKAY;
      case (axi_i.araddr)
        OFF_PC: rsp_d.rdata = DW'(pc_q);
        OFF_FLAGS: rsp_d.rdata = DW'(flags_q);
        OFF_CTRL: rsp_d.rdata = DW'(ctrl_q);
        OFF_STAT: rsp_d.rdata = DW'({taken_q, busy_q});
        default: begin
          rsp_d.rdata = 32'h0000_0000;
          rsp_d.rresp = RESP_SLVERR;
        end
      endcase
    end
    rsp_d.arready = !rsp_d.rvalid;
  end

  // branch sequencing
  always_comb begin
    state_d = state_q;
    busy_d = busy_q;
    taken_d = taken_q;
    pc_d = pc_q;
    tgt_d = tgt_q;
    flags_d = flags_q;
    ctrl_d = ctrl_q;
    if (wr_go && state_q == ST_IDLE && awaddr_q == OFF_PC) begin
      pc_d = PC_W'((DW'(pc_q) & ~wmask) | (wdata_q & wmask));
    end
    if (wr_go && state_q == ST_IDLE && awaddr_q == OFF_FLAGS) begin
      flags_d = (flags_q & ~wmask[7:0]) | (wdata_q[7:0] & wmask[7:0]);
    end
    case (state_q)
      ST_IDLE: begin
        if (start_w) begin
          ctrl_d = wdata_q[CTRL_W-1:0];
          taken_d = cmd_cond;
          if (cmd_cond) begin
            state_d = ST_TAKEN;
            busy_d = 1'b1;
            tgt_d = cmd_tgt;
          end else begin
            pc_d = cmd_next;
          end
        end
      end
      ST_TAKEN: begin
        pc_d = tgt_q;
        state_d = ST_IDLE;
        busy_d = 1'b0;
      end
      default: begin
        state_d = ST_IDLE;
        busy_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rsp_q <= '0;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      state_q <= ST_IDLE;
      busy_q <= 1'b0;
      taken_q <= 1'b0;
      pc_q <= PC_RST;
      tgt_q <= PC_RST;
      flags_q <= FLAGS_RST;
      ctrl_q <= CTRL_RST;
    end else begin
      rsp_q <= rsp_d;
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      state_q <= state_d;
      busy_q <= busy_d;
      taken_q <= taken_d;
      pc_q <= pc_d;
      tgt_q <= tgt_d;
      flags_q <= flags_d;
      ctrl_q <= ctrl_d;
    end
  end

  assign axi_o = rsp_q;
  assign pc_o = pc_q;
  assign busy_o = busy_q;

  // expected outcome of the named tests, worked out apart from cond_f
  logic named_exp;
  always_comb begin
    named_exp = 1'b0;
    if (cmd_op == OP_EQ) named_exp = flags_q[FLAG_Z];
    if (cmd_op == OP_NE) named_exp = ~flags_q[FLAG_Z];
    if (cmd_op == OP_CS || cmd_op == OP_LO) named_exp = flags_q[FLAG_C];
    if (cmd_op == OP_MI) named_exp = flags_q[FLAG_N];
    if (cmd_op == OP_PL) named_exp = ~flags_q[FLAG_N];
    if (cmd_op == OP_TS) named_exp = flags_q[FLAG_T];
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  bit_set_a: assert property (start_w && cmd_op == OP_BIT_SET && flags_q[cmd_s]
    |=> busy_o ##1 (pc_q == $past(cmd_tgt, 2))) else $error("bit set branch wrong");
  bit_clear_a: assert property (start_w && cmd_op == OP_BIT_CLEAR
    |=> busy_o == !$past(flags_q[cmd_s])) else $error("bit clear test wrong");
  carry_clear_a: assert property (start_w && cmd_op == OP_CC && flags_q[FLAG_C]
    |=> !busy_o && pc_q == PC_W'($past(pc_q) + 1'b1)) else $error("carry clear taken");
  same_higher_a: assert property (start_w && cmd_op == OP_SH
    |=> busy_o == !$past(flags_q[FLAG_C])) else $error("same or higher wrong");
  signed_ge_a: assert property (start_w && cmd_op == OP_GE
    |=> busy_o == !($past(flags_q[FLAG_N]) ^ $past(flags_q[FLAG_V])))
    else $error("signed ge wrong");
  signed_lt_a: assert property (start_w && cmd_op == OP_LT
    |=> busy_o == ($past(flags_q[FLAG_N]) ^ $past(flags_q[FLAG_V])))
    else $error("signed lt wrong");
  half_set_a: assert property (start_w && cmd_op == OP_HS && !flags_q[FLAG_H]
    |=> !busy_o && pc_q == PC_W'($past(pc_q) + 1'b1)) else $error("half set wrong");
  half_clear_a: assert property (start_w && cmd_op == OP_HC && !flags_q[FLAG_H]
    |=> busy_o ##1 !busy_o) else $error("half clear wrong");
  named_flags_a: assert property (start_w && cmd_op inside {OP_EQ, OP_NE, OP_CS,
    OP_LO, OP_MI, OP_PL, OP_TS} |=> busy_o == $past(named_exp))
    else $error("named flag test wrong");
  flags_hold_a: assert property (start_w || busy_o |=> $stable(flags_q))
    else $error("flags changed by branch");
  taken_len_a: assert property (busy_o |=> !busy_o) else $error("taken branch too long");

  taken_c: cover property (start_w && cmd_cond ##2 !busy_o);
  fall_c: cover property (start_w && !cmd_cond);
  refused_c: cover property (rsp_q.bvalid && rsp_q.bresp == RESP_SLVERR);
endmodule : cbu_branch_unit
`default_nettype wire

// ---- rtl/cbu_pkg.sv ----
package cbu_pkg;
  // datapath widths
  localparam int PC_W = 13;
  localparam int K_W = 7;
  localparam int AW = 8;
  localparam int DW = 32;
  // register byte addresses
  localparam logic [AW-1:0] OFF_PC = 8'h00;
  localparam logic [AW-1:0] OFF_FLAGS = 8'h04;
  localparam logic [AW-1:0] OFF_CTRL = 8'h08;
  localparam logic [AW-1:0] OFF_STAT = 8'h0C;
  // command register fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_S_LSB = 4;
  localparam int CTRL_K_LSB = 8;
  localparam int CTRL_W = 15;
  // status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_TAKEN_BIT = 1;
  // status_register flag positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  // reset values and bus answers
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [CTRL_W-1:0] CTRL_RST = 15'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    OP_BIT_SET = 4'h0, OP_BIT_CLEAR = 4'h1, OP_EQ = 4'h2, OP_NE = 4'h3,
    OP_CS = 4'h4, OP_CC = 4'h5, OP_SH = 4'h6, OP_LO = 4'h7,
    OP_MI = 4'h8, OP_PL = 4'h9, OP_GE = 4'hA, OP_LT = 4'hB,
    OP_HS = 4'hC, OP_HC = 4'hD, OP_TS = 4'hE, OP_NONE = 4'hF
  } cbu_op_e;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_TAKEN = 1'b1
  } cbu_state_e;

  typedef struct packed {
    logic [AW-1:0] awaddr;
    logic awvalid;
    logic [DW-1:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [AW-1:0] araddr;
    logic arvalid;
    logic rready;
  } cbu_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [DW-1:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } cbu_axi_rsp_s;
endpackage : cbu_pkg

// ---- verif/cbu_branch_unit_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module cbu_branch_unit_tb
  import cbu_pkg::*;
;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  cbu_axi_req_s req = '0;
  cbu_axi_rsp_s rsp;
  logic [PC_W-1:0] pc_o;
  logic busy_o;
  logic [15:0] lfsr_q = 16'h0C87;
  int n_fail = 0;
  int checks_done = 0;

  always #4 clk_i = ~clk_i;

  cbu_branch_unit u_cbu_branch_unit (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .axi_i(req),
    .axi_o(rsp),
    .pc_o(pc_o),
    .busy_o(busy_o)
  );

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // bounded wait step
  task automatic guard(inout int n);
    n++;
    if (n > 100) begin
      n_fail++;
      end_sim();
    end
  endtask : guard

  function automatic logic [15:0] rnd(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : rnd

  function automatic logic taken(input logic [3:0] op, input logic [2:0] s,
                                 input logic [7:0] f);
    case (op)
      4'h0: return f[s];
      4'h1: return !f[s];
      4'h2: return f[FLAG_Z];
      4'h3: return !f[FLAG_Z];
      4'h4, 4'h7: return f[FLAG_C];
      4'h5, 4'h6: return !f[FLAG_C];
      4'h8: return f[FLAG_N];
      4'h9: return !f[FLAG_N];
      4'hA: return !(f[FLAG_N] ^ f[FLAG_V]);
      4'hB: return f[FLAG_N] ^ f[FLAG_V];
      4'hC: return f[FLAG_H];
      4'hD: return !f[FLAG_H];
      4'hE: return f[FLAG_T];
      default: return 1'b0;
    endcase
  endfunction : taken

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d,
                    output logic [1:0] resp, output logic bsy);
    int n;
    logic aw_ok;
    logic w_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_i);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_i);
      guard(n);
      if (req.awvalid && rsp.awready) begin
        aw_ok = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (req.wvalid && rsp.wready) begin
        w_ok = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge clk_i);
      guard(n);
    end while (!rsp.bvalid);
    resp = rsp.bresp;
    bsy = busy_o;
    req.bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d,
                    output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge clk_i);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge clk_i);
      guard(n);
    end while (!rsp.arready);
    req.arvalid <= 1'b0;
    do begin
      @(posedge clk_i);
      guard(n);
    end while (!rsp.rvalid);
    d = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask : rd

  initial begin
    logic [1:0] resp;
    logic bsy;
    logic tk;
    logic [31:0] d;
    logic [7:0] flags;
    logic [2:0] s;
    logic [6:0] k;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] epc;
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    for (int i = 0; i < 48; i++) begin
      lfsr_q = rnd(lfsr_q);
      flags = lfsr_q[7:0];
      s = lfsr_q[10:8];
      lfsr_q = rnd(lfsr_q);
      // first pass: extreme offsets and pc wrap
      k = (i < 16) ? (i[0] ? 7'h3F : 7'h40) : lfsr_q[14:8];
      pc = (i < 16) ? (i[1] ? 13'h1FFF : 13'h0000) : lfsr_q[12:0];
      tk = taken(i[3:0], s, flags);
      epc = tk ? pc + {{6{k[6]}}, k} + 13'h0001 : pc + 13'h0001;
      wr(OFF_FLAGS, {24'h0, flags}, resp, bsy);
      wr(OFF_PC, {19'h0, pc}, resp, bsy);
      check({30'h0, resp}, {30'h0, RESP_OKAY});
      wr(OFF_CTRL, {17'h0, k, 1'b0, s, i[3:0]}, resp, bsy);
      check({31'h0, bsy}, {31'h0, tk});
      repeat (2) @(posedge clk_i);
      check({19'h0, pc_o}, {19'h0, epc});
      check({31'h0, busy_o}, 32'h0);
      rd(OFF_STAT, d, resp);
      check({31'h0, d[STAT_TAKEN_BIT]}, {31'h0, tk});
      check({30'h0, resp}, {30'h0, RESP_OKAY});
      rd(OFF_FLAGS, d, resp);
      check({24'h0, d[7:0]}, {24'h0, flags});
    end
    // reset in mid-run: state returns to its reset values
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check({19'h0, pc_o}, {19'h0, PC_RST});
    check({31'h0, busy_o}, 32'h0);
    check({31'h0, rsp.bvalid}, 32'h0);
    check({31'h0, rsp.rvalid}, 32'h0);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rd(OFF_CTRL, d, resp);
    check(d, {17'h0, CTRL_RST});
    rd(OFF_FLAGS, d, resp);
    check(d, {24'h0, FLAGS_RST});
    check({30'h0, resp}, {30'h0, RESP_OKAY});
    wr(8'h10, 32'hFFFF_FFFF, resp, bsy);
    check({30'h0, resp}, {30'h0, RESP_SLVERR});
    rd(8'h14, d, resp);
    check({d[29:0], resp}, {30'h0, RESP_SLVERR});
    wr(OFF_STAT, 32'h0000_0003, resp, bsy);
    check({30'h0, resp}, {30'h0, RESP_OKAY});
    end_sim();
  end
endmodule : cbu_branch_unit_tb
`default_nettype wire
